// ---- hw/smt_pkg.sv ----
// package of constants and types for the software managed translation buffer
package smt_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int SMT_ENTRIES = 32;
  localparam int SMT_IDX_W = 5;
  localparam int SMT_VA_W = 32;
  localparam int SMT_TAG_W = 16;
  localparam int SMT_USE_W = 16;
  localparam int SMT_BLK_SHIFT = 17;
  localparam int SMT_BLOCKS = 2;
  // page size codes: 4KB, 32KB, 256KB, 2048KB
  localparam logic [1:0] SMT_PG_4K = 2'h0;
  localparam logic [1:0] SMT_PG_32K = 2'h1;
  localparam logic [1:0] SMT_PG_256K = 2'h2;
  localparam logic [1:0] SMT_PG_2M = 2'h3;
  localparam int SMT_OFS_4K = 12;
  localparam int SMT_OFS_32K = 15;
  localparam int SMT_OFS_256K = 18;
  localparam int SMT_OFS_2M = 21;
  // ----------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] SMT_A_CTRL = 12'h000;
  localparam logic [11:0] SMT_A_IDX = 12'h004;
  localparam logic [11:0] SMT_A_VPN = 12'h008;
  localparam logic [11:0] SMT_A_PPN = 12'h00C;
  localparam logic [11:0] SMT_A_ATTR = 12'h010;
  localparam logic [11:0] SMT_A_USAGE = 12'h014;
  localparam logic [11:0] SMT_A_CMD = 12'h018;
  localparam logic [11:0] SMT_A_STAT = 12'h01C;
  localparam logic [11:0] SMT_A_IEN = 12'h020;
  localparam logic [11:0] SMT_A_ICLR = 12'h024;
  localparam logic [11:0] SMT_A_FADDR = 12'h028;
  localparam logic [11:0] SMT_A_BLK0 = 12'h030;
  localparam logic [11:0] SMT_A_BLK1 = 12'h038;
  // attr field positions
  localparam int SMT_AT_VALID = 0;
  localparam int SMT_AT_WRITE = 1;
  localparam int SMT_AT_READ = 2;
  localparam int SMT_AT_CACHE = 3;
  localparam int SMT_AT_SIZE = 4;
  localparam int SMT_AT_TAG = 16;
  // status bits
  localparam int SMT_ST_MISS = 0;
  localparam int SMT_ST_WPROT = 1;
  localparam int SMT_ST_RPROT = 2;
  // cmd codes
  localparam logic [1:0] SMT_CMD_WRITE = 2'h1;
  localparam logic [1:0] SMT_CMD_READ = 2'h2;
  localparam logic [31:0] SMT_RST_CTRL = 32'h00000000;

  typedef struct packed {
    logic valid;
    logic wr_ok;
    logic rd_ok;
    logic cacheable;
    logic [1:0] size;
    logic [SMT_TAG_W-1:0] tag;
    logic [SMT_VA_W-13:0] vpn;
    logic [SMT_VA_W-13:0] ppn;
    logic [SMT_USE_W-1:0] usage;
  } smt_entry_t;

  typedef struct packed {
    logic valid;
    logic [SMT_VA_W-SMT_BLK_SHIFT-1:0] base;
    logic [SMT_VA_W-SMT_BLK_SHIFT-1:0] mask;
    logic [SMT_VA_W-SMT_BLK_SHIFT-1:0] phys;
  } smt_block_t;
endpackage : smt_pkg

// ---- hw/smt_tlb.sv ----
// software managed translation buffer with apb access and lookup port
`timescale 1ns/100ps
module smt_tlb (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_fetch,
  input wire logic [31:0] acc_vaddr,
  input wire logic [15:0] address_space_tag,
  input wire logic translation_bypass_flag,
  output logic acc_done,
  output logic acc_trap,
  output logic [31:0] acc_paddr,
  output logic acc_cacheable,
  output logic irq
);
  import smt_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    smt_entry_t [SMT_ENTRIES-1:0] ent;
    smt_block_t [SMT_BLOCKS-1:0] blk;
    logic [SMT_IDX_W-1:0] idx;
    logic [31:0] vpn_r;
    logic [31:0] ppn_r;
    logic [31:0] attr_r;
    logic [31:0] usage_r;
    logic [2:0] stat;
    logic [2:0] ien;
    logic [31:0] faddr;
    logic [31:0] rdata;
    logic done;
    logic trap;
    logic [31:0] pa;
    logic cach;
  } smt_state_t;

  smt_state_t st;
  smt_state_t next_st;

  // ----------------------------------------
  // lookup
  // ----------------------------------------
  logic [SMT_ENTRIES-1:0] hit_vec;
  logic [SMT_BLOCKS-1:0] blk_hit;

  function automatic logic [19:0] pg_mask(input logic [1:0] sz);
    case (sz)
      SMT_PG_4K: pg_mask = 20'hFFFFF;
      SMT_PG_32K: pg_mask = 20'hFFFF8;
      SMT_PG_256K: pg_mask = 20'hFFFC0;
      default: pg_mask = 20'hFFE00;
    endcase
  endfunction : pg_mask

  genvar gi;
  generate
    for (gi = 0; gi < SMT_ENTRIES; gi++)
    begin : g_cmp
      // size-masked page number and tag compare
      assign hit_vec[gi] = st.ent[gi].valid && (st.ent[gi].tag == address_space_tag) &&
        (((acc_vaddr[31:12] ^ st.ent[gi].vpn) & pg_mask(st.ent[gi].size)) == 20'h00000);
    end
    for (gi = 0; gi < SMT_BLOCKS; gi++)
    begin : g_blk
      assign blk_hit[gi] = st.blk[gi].valid &&
        (((acc_vaddr[31:SMT_BLK_SHIFT] ^ st.blk[gi].base) & st.blk[gi].mask) == 15'h0000);
    end
  endgenerate

  logic apb_acc;
  logic apb_wr;
  logic addr_ok;
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite;
  assign pready = 1'b1;
  assign pslverr = apb_acc && !addr_ok;

  always_comb
  begin
    addr_ok = 1'b1;
    if (paddr == SMT_A_CTRL || paddr == SMT_A_IDX || paddr == SMT_A_VPN || paddr == SMT_A_PPN)
      addr_ok = 1'b1;
    else if (paddr == SMT_A_ATTR || paddr == SMT_A_USAGE || paddr == SMT_A_CMD || paddr == SMT_A_STAT)
      addr_ok = 1'b1;
    else if (paddr == SMT_A_IEN || paddr == SMT_A_ICLR || paddr == SMT_A_FADDR)
      addr_ok = 1'b1;
    else if (paddr[11:4] == SMT_A_BLK0[11:4] || paddr[11:4] == SMT_A_BLK1[11:4])
      addr_ok = !paddr[1] && !paddr[0];
    else
      addr_ok = 1'b0;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [2:0] ev;
    logic [4:0] hidx;
    logic any;
    logic [31:0] pa;
    logic [1:0] cnt;
    logic [2:0] slot;
    logic [4:0] osh;
    logic bsel;
    ev = 3'h0;
    hidx = 5'h00;
    any = 1'b0;
    pa = 32'h00000000;
    cnt = 2'h0;
    slot = 3'h0;
    osh = 5'h00;
    bsel = 1'b0;
    next_st = st;
    next_st.done = 1'b0;
    next_st.trap = 1'b0;
    for (int i = SMT_ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        hidx = 5'(i);
        any = 1'b1;
      end
    end
    // one cycle lookup, shared by fetch and data
    if (acc_req)
    begin
      next_st.done = 1'b1;
      if (translation_bypass_flag)
      begin
        next_st.pa = acc_vaddr;
        next_st.cach = 1'b1;
      end
      else if (any)
      begin
        case (st.ent[hidx].size)
          SMT_PG_4K: osh = 5'(SMT_OFS_4K);
          SMT_PG_32K: osh = 5'(SMT_OFS_32K);
          SMT_PG_256K: osh = 5'(SMT_OFS_256K);
          default: osh = 5'(SMT_OFS_2M);
        endcase
        pa = ({st.ent[hidx].ppn, 12'h000} & (32'hFFFFFFFF << osh)) |
          (acc_vaddr & ~(32'hFFFFFFFF << osh));
        if (acc_write && !st.ent[hidx].wr_ok)
        begin
          next_st.trap = 1'b1;
          ev[SMT_ST_WPROT] = 1'b1;
          next_st.faddr = acc_vaddr;
        end
        else if (!acc_write && !acc_fetch && !st.ent[hidx].rd_ok)
        begin
          next_st.trap = 1'b1;
          ev[SMT_ST_RPROT] = 1'b1;
          next_st.faddr = acc_vaddr;
        end
        else
        begin
          next_st.pa = pa;
          next_st.cach = st.ent[hidx].cacheable;
          // usage counters: one per eighth of the page, saturating
          slot = 3'(pa >> (osh - 5'd3));
          cnt = st.ent[hidx].usage[2*slot +: 2];
          if (cnt != 2'h3)
            next_st.ent[hidx].usage[2*slot +: 2] = cnt + 2'h1;
        end
      end
      else if (blk_hit != 2'h0)
      begin
        bsel = !blk_hit[0];
        next_st.pa = {(st.blk[bsel].phys & st.blk[bsel].mask) |
          (acc_vaddr[31:SMT_BLK_SHIFT] & ~st.blk[bsel].mask), acc_vaddr[SMT_BLK_SHIFT-1:0]};
        next_st.cach = 1'b1;
      end
      else
      begin
        next_st.trap = 1'b1;
        ev[SMT_ST_MISS] = 1'b1;
        next_st.faddr = acc_vaddr;
      end
    end

    // software access through registers only, no table walker
    if (apb_wr && addr_ok)
    begin
      if (paddr == SMT_A_IDX)
        next_st.idx = pwdata[SMT_IDX_W-1:0];
      else if (paddr == SMT_A_VPN)
        next_st.vpn_r = pwdata;
      else if (paddr == SMT_A_PPN)
        next_st.ppn_r = pwdata;
      else if (paddr == SMT_A_ATTR)
        next_st.attr_r = pwdata;
      else if (paddr == SMT_A_USAGE)
        next_st.usage_r = pwdata;
      else if (paddr == SMT_A_IEN)
        next_st.ien = pwdata[2:0];
      else if (paddr == SMT_A_CMD && pwdata[1:0] == SMT_CMD_WRITE)
      begin
        next_st.ent[st.idx].valid = st.attr_r[SMT_AT_VALID];
        next_st.ent[st.idx].wr_ok = st.attr_r[SMT_AT_WRITE];
        next_st.ent[st.idx].rd_ok = st.attr_r[SMT_AT_READ];
        next_st.ent[st.idx].cacheable = st.attr_r[SMT_AT_CACHE];
        next_st.ent[st.idx].size = st.attr_r[SMT_AT_SIZE +: 2];
        next_st.ent[st.idx].tag = st.attr_r[SMT_AT_TAG +: SMT_TAG_W];
        next_st.ent[st.idx].vpn = st.vpn_r[31:12];
        next_st.ent[st.idx].ppn = st.ppn_r[31:12];
        next_st.ent[st.idx].usage = st.usage_r[SMT_USE_W-1:0];
      end
      else if (paddr == SMT_A_CMD && pwdata[1:0] == SMT_CMD_READ)
      begin
        next_st.vpn_r = {st.ent[st.idx].vpn, 12'h000};
        next_st.ppn_r = {st.ent[st.idx].ppn, 12'h000};
        next_st.attr_r = {st.ent[st.idx].tag, 10'h000, st.ent[st.idx].size, st.ent[st.idx].cacheable,
          st.ent[st.idx].rd_ok, st.ent[st.idx].wr_ok, st.ent[st.idx].valid};
        next_st.usage_r = {16'h0000, st.ent[st.idx].usage};
      end
      else if (paddr[11:4] == SMT_A_BLK0[11:4] || paddr[11:4] == SMT_A_BLK1[11:4])
      begin
        bsel = paddr[3];
        if (!paddr[2])
        begin
          next_st.blk[bsel].base = pwdata[31:SMT_BLK_SHIFT];
          next_st.blk[bsel].valid = pwdata[0];
        end
        else
        begin
          next_st.blk[bsel].phys = pwdata[31:SMT_BLK_SHIFT];
          next_st.blk[bsel].mask = ~pwdata[SMT_BLK_SHIFT-1:2];
        end
      end
    end
    // sticky status: set wins over clear
    if (apb_wr && paddr == SMT_A_ICLR)
      next_st.stat = (st.stat & ~pwdata[2:0]) | ev;
    else
      next_st.stat = st.stat | ev;

    next_st.rdata = 32'h00000000;
    if (psel && !penable && !pwrite)
    begin
      if (paddr == SMT_A_IDX)
        next_st.rdata = {27'h0000000, st.idx};
      else if (paddr == SMT_A_VPN)
        next_st.rdata = st.vpn_r;
      else if (paddr == SMT_A_PPN)
        next_st.rdata = st.ppn_r;
      else if (paddr == SMT_A_ATTR)
        next_st.rdata = st.attr_r;
      else if (paddr == SMT_A_USAGE)
        next_st.rdata = st.usage_r;
      else if (paddr == SMT_A_STAT)
        next_st.rdata = {29'h00000000, st.stat};
      else if (paddr == SMT_A_IEN)
        next_st.rdata = {29'h00000000, st.ien};
      else if (paddr == SMT_A_FADDR)
        next_st.rdata = st.faddr;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign prdata = st.rdata;
  assign acc_done = st.done;
  assign acc_trap = st.trap;
  assign acc_paddr = st.pa;
  assign acc_cacheable = st.cach;
  assign irq = |(st.stat & st.ien);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_miss_trap;
    @(posedge ref_clk) disable iff (sys_rst)
    acc_req && !translation_bypass_flag && hit_vec == 32'h0 && blk_hit == 2'h0 |=> acc_trap && st.stat[0];
  endproperty
  a_miss_trap: assert property (p_miss_trap) else $error("miss did not trap");

  property p_bypass;
    @(posedge ref_clk) disable iff (sys_rst)
    acc_req && translation_bypass_flag |=> !acc_trap && acc_paddr == $past(acc_vaddr);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass translated");

  property p_wprot;
    @(posedge ref_clk) disable iff (sys_rst)
    acc_req && acc_write && !translation_bypass_flag && hit_vec[0] && !st.ent[0].wr_ok |=> acc_trap;
  endproperty
  a_wprot: assert property (p_wprot) else $error("store to readonly page accepted");

  property p_tag;
    @(posedge ref_clk) disable iff (sys_rst)
    acc_req && !translation_bypass_flag && hit_vec[0] && !acc_write && st.ent[0].rd_ok
      |=> !acc_trap && acc_paddr[11:0] == $past(acc_vaddr[11:0]);
  endproperty
  a_tag: assert property (p_tag) else $error("hit lost page offset");

  property p_done;
    @(posedge ref_clk) disable iff (sys_rst)
    acc_req |=> acc_done ##1 (acc_done == $past(acc_req));
  endproperty
  a_done: assert property (p_done) else $error("lookup answer late");

  property p_irq;
    @(posedge ref_clk) disable iff (sys_rst)
    st.stat[0] && st.ien[0] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_sat;
    @(posedge ref_clk) disable iff (sys_rst)
    st.ent[0].usage[1:0] == 2'h3 && !(apb_wr && paddr == SMT_A_CMD) |=> st.ent[0].usage[1:0] == 2'h3;
  endproperty
  a_sat: assert property (p_sat) else $error("usage counter wrapped");

  property p_load;
    @(posedge ref_clk) disable iff (sys_rst)
    apb_wr && paddr == SMT_A_CMD && pwdata[1:0] == SMT_CMD_WRITE && st.idx == 5'h00
      |=> st.ent[0].tag == $past(st.attr_r[31:16]) && st.ent[0].size == $past(st.attr_r[5:4]);
  endproperty
  a_load: assert property (p_load) else $error("entry load wrong");

  c_miss: cover property (@(posedge ref_clk) disable iff (sys_rst) acc_req && !translation_bypass_flag ##1 acc_trap);
  c_hit: cover property (@(posedge ref_clk) disable iff (sys_rst) acc_req && hit_vec != 32'h0 ##1 !acc_trap);
  c_blk: cover property (@(posedge ref_clk) disable iff (sys_rst) acc_req && hit_vec == 32'h0 && blk_hit != 2'h0);
endmodule : smt_tlb

// ---- tb/smt_lsu_model.sv ----
// fetch and load/store side that issues lookups to the translation buffer
`timescale 1ns/100ps
module smt_lsu_model (
  input wire logic ref_clk,
  output logic acc_req,
  output logic acc_write,
  output logic acc_fetch,
  output logic [31:0] acc_vaddr,
  output logic [15:0] address_space_tag,
  output logic translation_bypass_flag
);
  initial
  begin
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_fetch = 1'b0;
    acc_vaddr = 32'h00000000;
    address_space_tag = 16'h0000;
    translation_bypass_flag = 1'b0;
  end
  // ----------------------------------------
  // one lookup; entries are never written from this side
  // ----------------------------------------
  task automatic look(input logic w, input logic f, input logic [31:0] va, input logic [15:0] tg, input logic byp);
    @(posedge ref_clk);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_fetch <= f;
    acc_vaddr <= va;
    address_space_tag <= tg;
    translation_bypass_flag <= byp;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    // released address shows the inverse so a stale value never matches
    acc_vaddr <= ~va;
  endtask : look
endmodule : smt_lsu_model

// ---- tb/smt_tlb_test.sv ----
// self-checking bench for the software managed translation buffer
`timescale 1ns/100ps
module smt_tlb_test;
  import smt_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, acc_paddr, acc_vaddr, rnd, rdv, vb, pb, om;
  logic pready, pslverr, acc_done, acc_trap, acc_cacheable, irq, last_err;
  logic acc_req, acc_write, acc_fetch, translation_bypass_flag;
  logic [15:0] address_space_tag;
  logic [34:0] notes[$];
  logic [34:0] nt;
  int n_fail = 0;
  int cmp_count = 0;
  int ofs_t[4] = '{SMT_OFS_4K, SMT_OFS_32K, SMT_OFS_256K, SMT_OFS_2M};

  always #2.5 ref_clk = ~ref_clk;

  smt_tlb smt_tlb_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_req(acc_req),
    .acc_write(acc_write), .acc_fetch(acc_fetch), .acc_vaddr(acc_vaddr), .address_space_tag(address_space_tag),
    .translation_bypass_flag(translation_bypass_flag), .acc_done(acc_done), .acc_trap(acc_trap),
    .acc_paddr(acc_paddr), .acc_cacheable(acc_cacheable), .irq(irq));
  smt_lsu_model smt_lsu_model_i (.ref_clk(ref_clk), .acc_req(acc_req), .acc_write(acc_write),
    .acc_fetch(acc_fetch), .acc_vaddr(acc_vaddr), .address_space_tag(address_space_tag),
    .translation_bypass_flag(translation_bypass_flag));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      n_fail++;
      end_of_test();
    end
    else
    begin
      rdv = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(e, rdv);
  endtask : rd

  task automatic irq_is(input logic e);
    @(negedge ref_clk);
    chk(e, irq);
  endtask : irq_is

  task automatic ld(input logic [4:0] i, input logic [31:0] v, input logic [31:0] p, input logic [31:0] at);
    apb(1'b1, SMT_A_IDX, {27'h0, i});
    apb(1'b1, SMT_A_VPN, v);
    apb(1'b1, SMT_A_PPN, p);
    apb(1'b1, SMT_A_ATTR, at);
    apb(1'b1, SMT_A_USAGE, 32'h00000000);
    apb(1'b1, SMT_A_CMD, {30'h0, SMT_CMD_WRITE});
  endtask : ld

  // note layout: trap, check cacheable, cacheable, physical address
  task automatic lk(input logic w, input logic f, input logic [31:0] va, input logic [15:0] tg, input logic byp,
    input logic [34:0] note);
    notes.push_back(note);
    smt_lsu_model_i.look(w, f, va, tg, byp);
    repeat (2) @(posedge ref_clk);
  endtask : lk

  // ----------------------------------------
  // result monitor and watchdog
  // ----------------------------------------
  always @(negedge ref_clk)
  begin
    if (acc_done === 1'b1)
    begin
      if (notes.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        nt = notes.pop_front();
        chk(nt[34], acc_trap);
        if (nt[34] === 1'b0)
        begin
          chk(nt[31:0], acc_paddr);
          if (nt[33])
            chk(nt[32], acc_cacheable);
        end
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rnd = 32'h00000001;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(SMT_A_STAT, 32'h0);
    irq_is(1'b0);
    rd(12'h0FC, 32'h0);
    chk(32'h1, last_err);
    lk(1'b0, 1'b0, 32'h23456788, 16'h0001, 1'b0, {1'b1, 34'h0});
    rd(SMT_A_STAT, 32'h1);
    rd(SMT_A_FADDR, 32'h23456788);
    irq_is(1'b0);
    apb(1'b1, SMT_A_IEN, 32'h1);
    irq_is(1'b1);
    apb(1'b1, SMT_A_ICLR, 32'h1);
    irq_is(1'b0);
    for (int s = 0; s < 4; s++)
    begin
      vb = {4'(s + 1), 28'h0};
      pb = {4'(s + 9), 28'h0};
      ld((s == 3) ? 5'd31 : 5'(s), vb, pb, {16'hA5A5, 10'h0, 2'(s), 1'(s), 3'b111});
      rnd = lfsr(rnd);
      om = (32'h1 << ofs_t[s]) - 32'h1;
      lk(1'b0, 1'b0, vb | (rnd & om), 16'hA5A5, 1'b0, {2'b01, 1'(s), pb | (rnd & om)});
      lk(1'b0, 1'b1, vb | (32'h1 << ofs_t[s]), 16'hA5A5, 1'b0, {1'b1, 34'h0});
      lk(1'b0, 1'b0, vb, 16'hA5A4, 1'b0, {1'b1, 34'h0});
    end
    ld(5'd0, 32'h70000000, 32'h78000000, 32'h00420007);
    repeat (4) lk(1'b0, 1'b0, 32'h70000100, 16'h0042, 1'b0, {3'b010, 32'h78000100});
    lk(1'b1, 1'b0, 32'h70000A04, 16'h0042, 1'b0, {3'b010, 32'h78000A04});
    apb(1'b1, SMT_A_IDX, 32'h0);
    apb(1'b1, SMT_A_CMD, {30'h0, SMT_CMD_READ});
    rd(SMT_A_USAGE, 32'h00000403);
    rd(SMT_A_ATTR, 32'h00420007);
    apb(1'b1, SMT_A_ICLR, 32'h7);
    apb(1'b1, SMT_A_IEN, 32'h2);
    ld(5'd0, 32'h71000000, 32'h79000000, 32'h00420005);
    lk(1'b0, 1'b0, 32'h72000000, 16'h0042, 1'b0, {1'b1, 34'h0});
    irq_is(1'b0);
    lk(1'b1, 1'b0, 32'h71000010, 16'h0042, 1'b0, {1'b1, 34'h0});
    rd(SMT_A_STAT, 32'h3);
    irq_is(1'b1);
    lk(1'b0, 1'b0, 32'h71000010, 16'h0042, 1'b0, {3'b010, 32'h79000010});
    ld(5'd12, 32'h73000000, 32'h7A000000, 32'h00420003);
    lk(1'b0, 1'b0, 32'h73000020, 16'h0042, 1'b0, {1'b1, 34'h0});
    lk(1'b0, 1'b1, 32'h73000020, 16'h0042, 1'b0, {3'b010, 32'h7A000020});
    rd(SMT_A_STAT, 32'h7);
    rnd = lfsr(rnd);
    lk(1'b1, 1'b0, rnd, 16'h0000, 1'b1, {3'b011, rnd});
    apb(1'b1, SMT_A_BLK0 + 12'h004, 32'h90000004);
    apb(1'b1, SMT_A_BLK0, 32'h80000001);
    lk(1'b0, 1'b1, 32'h80020123, 16'h0007, 1'b0, {3'b011, 32'h90020123});
    lk(1'b0, 1'b1, 32'h80040000, 16'h0007, 1'b0, {1'b1, 34'h0});
    apb(1'b1, SMT_A_BLK1 + 12'h004, 32'hA0000000);
    apb(1'b1, SMT_A_BLK1, 32'hC0000001);
    lk(1'b0, 1'b0, 32'hC0001234, 16'h0007, 1'b0, {3'b011, 32'hA0001234});
    chk(32'h0, notes.size());
    end_of_test();
  end
endmodule : smt_tlb_test
